// *** rtl/text_color_attribute_regs.v ***
// APB register bank for text spacing, colour attributes and user glyph memory address
`timescale 1ns/1ps
`include "text_attr_consts.vh"

// Behaviour
// - The wrap line gap height in pixels equals the 5-bit line gap field.
// - The line gap is painted in background colour and is never enlarged.
// - The space between characters equals the 6-bit spacing field, 0 to 63 pixels.
// - The character space is filled with background colour and is never enlarged.
// - Foreground red uses bits 7:5, 7:3 or 7:0 for 8, 16 or 24-bit colour.
// - Green uses bits 7:5, 7:2 or 7:0 for 8, 16 or 24-bit colour.
// - Blue uses bits 7:6, 7:3 or 7:0 for 8, 16 or 24-bit colour.
// - Background components follow the same mapping and reset to zero.
// - Each foreground component register resets to all ones.
// - The user glyph start address is four byte registers, lowest byte first.
// - User glyph height is 16, 24 or 32 dots, coded 0 to 2.
module text_color_attribute_regs (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        task_busy,
    output wire [4:0]  line_gap_px,
    output wire [5:0]  char_space_px,
    output wire [23:0] fore_color,
    output wire [23:0] back_color,
    output wire [1:0]  color_depth,
    output wire [31:0] user_glyph_start_addr,
    output wire [1:0]  glyph_height_sel,
    output wire [5:0]  glyph_height_dots,
    output wire        busy_write_seen
);

    reg  [4:0]  line_gap_reg_q;
    reg  [7:0]  glyph_spacing_reg_q;
    reg  [7:0]  fore_red_reg_q;
    reg  [7:0]  fore_green_reg_q;
    reg  [7:0]  fore_blue_reg_q;
    reg  [7:0]  back_red_reg_q;
    reg  [7:0]  back_green_reg_q;
    reg  [7:0]  back_blue_reg_q;
    reg  [1:0]  glyph_height_q;
    reg  [1:0]  color_depth_q;
    reg         busy_write_q;
    reg  [31:0] rd_d;

    wire [7:0]  idx;
    wire        addr_ok;
    wire        wr_en;
    wire        lane0;
    wire        attr_hit;
    wire        sync_busy;
    wire [31:0] glyph_start;

    // Per-register write strobes
    wire        wr_lane0;
    wire        wr_line_gap;
    wire        wr_spacing;
    wire        wr_fore_red;
    wire        wr_fore_green;
    wire        wr_fore_blue;
    wire        wr_back_red;
    wire        wr_back_green;
    wire        wr_back_blue;
    wire [3:0]  wr_start;
    wire        wr_height;
    wire        wr_depth;
    wire        height_code_ok;
    wire        depth_code_ok;
    wire        busy_set;
    wire        busy_clr;

    // Colour mapping
    wire [23:0] fore_raw;
    wire [23:0] back_raw;
    reg  [23:0] depth_mask;
    reg  [5:0]  dots_d;

    // Busy synchroniser
    reg         busy_s1_q;
    reg         busy_s2_q;
    reg         busy_s3_q;
    reg         busy_q;

    // Any address bit outside the word index makes the access unmapped
    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign lane0   = pstrb[0];
    // Zero wait states: every access phase completes in one cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Busy flag comes from another part of the controller, so treat it as asynchronous
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
            busy_s3_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            busy_s1_q <= task_busy;
            busy_s2_q <= busy_s1_q;
            busy_s3_q <= busy_s2_q;
            if (busy_s2_q == busy_s3_q) begin
                busy_q <= busy_s3_q;
            end
        end
    end
    assign sync_busy = busy_q;

    assign attr_hit = (idx >= `IDX_LINE_GAP) && (idx <= `IDX_BACK_BLUE);

    // Reserved and unmapped indices raise no strobe, so writes to them vanish
    assign wr_lane0      = wr_en && lane0;
    assign wr_line_gap   = wr_lane0 && (idx == `IDX_LINE_GAP);
    assign wr_spacing    = wr_lane0 && (idx == `IDX_GLYPH_SPACING);
    assign wr_fore_red   = wr_lane0 && (idx == `IDX_FORE_RED);
    assign wr_fore_green = wr_lane0 && (idx == `IDX_FORE_GREEN);
    assign wr_fore_blue  = wr_lane0 && (idx == `IDX_FORE_BLUE);
    assign wr_back_red   = wr_lane0 && (idx == `IDX_BACK_RED);
    assign wr_back_green = wr_lane0 && (idx == `IDX_BACK_GREEN);
    assign wr_back_blue  = wr_lane0 && (idx == `IDX_BACK_BLUE);
    assign wr_height     = wr_lane0 && (idx == `IDX_GLYPH_HEIGHT);
    assign wr_depth      = wr_lane0 && (idx == `IDX_COLOR_DEPTH);
    // Code 3 is neither a height nor a depth, so the old value is kept
    assign height_code_ok = (pwdata[1:0] != 2'h3);
    assign depth_code_ok  = (pwdata[1:0] != 2'h3);

    // Writes still land while busy; the sticky flag tells software a line gap to background blue write broke the protocol
    assign busy_set = wr_lane0 && attr_hit && sync_busy;
    assign busy_clr = wr_depth && pwdata[7];

    // Bits 7:5 are not stored and read back as zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_gap_reg_q <= `RST_LINE_GAP;
        end else if (wr_line_gap) begin
            line_gap_reg_q <= pwdata[4:0];
        end
    end

    // Bits 7:6 are kept so software reads back what it wrote; only 5:0 reach the renderer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glyph_spacing_reg_q <= `RST_SPACING_REG;
        end else if (wr_spacing) begin
            glyph_spacing_reg_q <= pwdata[7:0];
        end
    end

    // Foreground resets to white so default text shows on the zero background
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fore_red_reg_q <= `RST_FORE;
        end else if (wr_fore_red) begin
            fore_red_reg_q <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fore_green_reg_q <= `RST_FORE;
        end else if (wr_fore_green) begin
            fore_green_reg_q <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fore_blue_reg_q <= `RST_FORE;
        end else if (wr_fore_blue) begin
            fore_blue_reg_q <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            back_red_reg_q <= `RST_BACK;
        end else if (wr_back_red) begin
            back_red_reg_q <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            back_green_reg_q <= `RST_BACK;
        end else if (wr_back_green) begin
            back_green_reg_q <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            back_blue_reg_q <= `RST_BACK;
        end else if (wr_back_blue) begin
            back_blue_reg_q <= pwdata[7:0];
        end
    end

    // Each byte is independent, so the host may update them in any order
    genvar sb;
    generate
        for (sb = 0; sb < 4; sb = sb + 1) begin : g_start_byte
            // The index is a constant per byte, so each strobe is a plain compare
            localparam [7:0] BYTE_IDX = `IDX_GLYPH_START0 + sb;
            reg        [7:0] byte_q;
            assign wr_start[sb] = wr_lane0 && (idx == BYTE_IDX);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    byte_q <= `RST_GLYPH_BYTE;
                end else if (wr_start[sb]) begin
                    byte_q <= pwdata[7:0];
                end
            end
            assign glyph_start[8*sb+7:8*sb] = byte_q;
        end
    endgenerate

    // Only user-defined glyphs use this height; built-in fonts ignore it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glyph_height_q <= `RST_GLYPH_HEIGHT;
        end else if (wr_height && height_code_ok) begin
            glyph_height_q <= pwdata[1:0];
        end
    end

    // Depth also selects the colour mask below
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            color_depth_q <= `RST_COLOR_DEPTH;
        end else if (wr_depth && depth_code_ok) begin
            color_depth_q <= pwdata[1:0];
        end
    end

    // A set wins over a clear in the same cycle, so no protocol break is lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_write_q <= 1'b0;
        end else if (busy_set) begin
            busy_write_q <= 1'b1;
        end else if (busy_clr) begin
            busy_write_q <= 1'b0;
        end
    end

    // Read decode is combinational; prdata registers it in the setup cycle, ahead of the access cycle
    always @* begin
        rd_d = 32'h00000000;
        if (addr_ok) begin
            case (idx)
                `IDX_LINE_GAP:      rd_d = {27'h0000000, line_gap_reg_q};
                `IDX_GLYPH_SPACING: rd_d = {24'h000000, glyph_spacing_reg_q};
                `IDX_FORE_RED:      rd_d = {24'h000000, fore_red_reg_q};
                `IDX_FORE_GREEN:    rd_d = {24'h000000, fore_green_reg_q};
                `IDX_FORE_BLUE:     rd_d = {24'h000000, fore_blue_reg_q};
                `IDX_BACK_RED:      rd_d = {24'h000000, back_red_reg_q};
                `IDX_BACK_GREEN:    rd_d = {24'h000000, back_green_reg_q};
                `IDX_BACK_BLUE:     rd_d = {24'h000000, back_blue_reg_q};
                `IDX_GLYPH_START0:  rd_d = {24'h000000, glyph_start[7:0]};
                `IDX_GLYPH_START1:  rd_d = {24'h000000, glyph_start[15:8]};
                `IDX_GLYPH_START2:  rd_d = {24'h000000, glyph_start[23:16]};
                `IDX_GLYPH_START3:  rd_d = {24'h000000, glyph_start[31:24]};
                `IDX_GLYPH_HEIGHT:  rd_d = {30'h00000000, glyph_height_q};
                // Bit 6 mirrors the synchronised busy flag so software can poll it here
                `IDX_COLOR_DEPTH:   rd_d = {24'h000000, busy_write_q, sync_busy,
                                            4'h0, color_depth_q};
                default:            rd_d = 32'h00000000;
            endcase
        end
    end

    // Captured in the setup cycle so read data stands through the whole access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // Used bits sit at the top of each byte; lower bits are forced to zero
    assign fore_raw = {fore_red_reg_q, fore_green_reg_q, fore_blue_reg_q};
    assign back_raw = {back_red_reg_q, back_green_reg_q, back_blue_reg_q};

    // Blue keeps one bit fewer than red and green at 8-bit depth
    always @* begin
        depth_mask = 24'hFFFFFF;
        case (color_depth_q)
            `DEPTH_8BIT:  depth_mask = `COLOR_MASK_8BIT;
            `DEPTH_16BIT: depth_mask = `COLOR_MASK_16BIT;
            `DEPTH_24BIT: depth_mask = 24'hFFFFFF;
            default:      depth_mask = 24'hFFFFFF;
        endcase
    end

    // One mask serves both colours, so foreground and background never disagree on depth
    genvar comp;
    generate
        for (comp = 0; comp < 3; comp = comp + 1) begin : g_component
            assign fore_color[8*comp+7:8*comp] = fore_raw[8*comp+7:8*comp] &
                                                 depth_mask[8*comp+7:8*comp];
            assign back_color[8*comp+7:8*comp] = back_raw[8*comp+7:8*comp] &
                                                 depth_mask[8*comp+7:8*comp];
        end
    endgenerate

    // Gap and space are raw pixel counts; the renderer fills them with back_color
    // and never applies the enlargement factors to them
    assign line_gap_px   = line_gap_reg_q;
    assign char_space_px = glyph_spacing_reg_q[5:0];
    assign color_depth   = color_depth_q;
    assign user_glyph_start_addr = glyph_start;
    assign glyph_height_sel = glyph_height_q;

    // Code 3 never reaches the register; the default only keeps the decode complete
    always @* begin
        dots_d = 6'h10;
        case (glyph_height_q)
            `GLYPH_H16: dots_d = 6'h10;
            `GLYPH_H24: dots_d = 6'h18;
            `GLYPH_H32: dots_d = 6'h20;
            default:    dots_d = 6'h10;
        endcase
    end
    assign glyph_height_dots = dots_d;
    assign busy_write_seen = busy_write_q;

endmodule // text_color_attribute_regs

// *** rtl/text_attr_consts.vh ***
// Offsets, field widths, reset values and encodings of the text and colour attribute registers
`ifndef TEXT_ATTR_CONSTS_VH
`define TEXT_ATTR_CONSTS_VH

// Register indices; the byte address on APB is four times the index
`define IDX_RSVD_A        8'hCE
`define IDX_RSVD_B        8'hCF
`define IDX_LINE_GAP      8'hD0
`define IDX_GLYPH_SPACING 8'hD1
`define IDX_FORE_RED      8'hD2
`define IDX_FORE_GREEN    8'hD3
`define IDX_FORE_BLUE     8'hD4
`define IDX_BACK_RED      8'hD5
`define IDX_BACK_GREEN    8'hD6
`define IDX_BACK_BLUE     8'hD7
`define IDX_RSVD_C        8'hD8
`define IDX_RSVD_D        8'hD9
`define IDX_RSVD_E        8'hDA
`define IDX_GLYPH_START0  8'hDB
`define IDX_GLYPH_START1  8'hDC
`define IDX_GLYPH_START2  8'hDD
`define IDX_GLYPH_START3  8'hDE
`define IDX_GLYPH_HEIGHT  8'hE8
`define IDX_COLOR_DEPTH   8'hE9

// Field widths
`define LINE_GAP_W        5
`define SPACING_W         6
`define GLYPH_HEIGHT_W    2
`define COLOR_DEPTH_W     2

// Reset values
`define RST_LINE_GAP      5'h00
`define RST_SPACING_REG   8'h00
`define RST_FORE          8'hFF
`define RST_BACK          8'h00
`define RST_GLYPH_START   32'h00000000
`define RST_GLYPH_BYTE    8'h00
`define RST_GLYPH_HEIGHT  2'h0
`define RST_COLOR_DEPTH   2'h0

// Colour depth encodings
`define DEPTH_8BIT        2'h0
`define DEPTH_16BIT       2'h1
`define DEPTH_24BIT       2'h2

// Kept bits of {red, green, blue} at 8 and 16-bit colour depth; 24-bit depth keeps every bit
`define COLOR_MASK_8BIT   24'hE0E0C0
`define COLOR_MASK_16BIT  24'hF8FCF8

// User glyph heights in dots
`define GLYPH_H16         2'h0
`define GLYPH_H24         2'h1
`define GLYPH_H32         2'h2

`endif

// *** dv/text_color_attribute_regs_checker.sv ***
// Assertion checker for the text and colour attribute register bank
`timescale 1ns/1ps
module text_color_attribute_regs_checker (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic [4:0]  line_gap_px,
    input logic [5:0]  char_space_px,
    input logic [23:0] fore_color,
    input logic [1:0]  color_depth,
    input logic [31:0] user_glyph_start_addr,
    input logic [1:0]  glyph_height_sel,
    input logic [5:0]  glyph_height_dots
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(a); psel && penable && pwrite && pstrb[0] && paddr == a; endsequence
    sequence s_rd(a); psel && !penable && !pwrite && paddr == a; endsequence
    property p_gap; s_wr(12'h340) |=> line_gap_px == $past(pwdata[4:0]); endproperty
    a_gap: assert property (p_gap) else $error("line gap not loaded");
    property p_space; s_wr(12'h344) |=> char_space_px == $past(pwdata[5:0]); endproperty
    a_space: assert property (p_space) else $error("spacing not loaded");
    property p_gap_rd; s_rd(12'h340) ##1 penable |-> prdata == {27'h0, line_gap_px}; endproperty
    a_gap_rd: assert property (p_gap_rd) else $error("line gap read wrong");
    property p_mask8; color_depth == 2'h0 |-> (fore_color & 24'h1F1F3F) == 24'h0; endproperty
    a_mask8: assert property (p_mask8) else $error("8-bit colour mask wrong");
    property p_rst; $rose(presetn) |-> fore_color == 24'hE0E0C0; endproperty
    a_rst: assert property (p_rst) else $error("foreground reset wrong");
    property p_glyph;
        s_wr(12'h36C) |=> user_glyph_start_addr[7:0] == $past(pwdata[7:0])
            && user_glyph_start_addr[31:8] == $past(user_glyph_start_addr[31:8]);
    endproperty
    a_glyph: assert property (p_glyph) else $error("glyph byte 0 wrong");
    property p_rsvd; s_rd(12'h360) |=> prdata == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    property p_dots;
        glyph_height_dots == (glyph_height_sel == 2'h0 ? 6'h10 :
                              glyph_height_sel == 2'h1 ? 6'h18 : 6'h20);
    endproperty
    a_dots: assert property (p_dots) else $error("glyph height dots wrong");
endmodule // text_color_attribute_regs_checker

bind text_color_attribute_regs text_color_attribute_regs_checker u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .line_gap_px, .char_space_px, .fore_color, .color_depth, .user_glyph_start_addr,
    .glyph_height_sel, .glyph_height_dots);

// *** dv/text_color_attribute_regs_tb_top.sv ***
// Self-checking testbench for the text and colour attribute register bank
`timescale 1ns/1ps
`include "text_attr_consts.vh"
module text_color_attribute_regs_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, task_busy = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0]  pstrb = 4'hF;
    wire         pready, pslverr, busy_write_seen;
    wire  [4:0]  line_gap_px;
    wire  [5:0]  char_space_px, glyph_height_dots;
    wire  [23:0] fore_color, back_color;
    wire  [1:0]  color_depth, glyph_height_sel;
    wire  [31:0] prdata, user_glyph_start_addr;
    int          fails = 0, n_checks = 0, cyc = 0;
    // Row fields: index, write data, reset value, read-back value
    logic [31:0] rows [18] = '{32'hD0FF001F, 32'hD1FF00FF, 32'hD2A5FFA5, 32'hD35AFF5A,
        32'hD43CFF3C, 32'hD5C300C3, 32'hD6960096, 32'hD7690069, 32'hDB110011,
        32'hDC220022, 32'hDD330033, 32'hDE440044, 32'hCEFF0000, 32'hCFFF0000,
        32'hD8FF0000, 32'hD9FF0000, 32'hDAFF0000, 32'hFFFF0000};
    logic [23:0] exp_f [3] = '{24'hA04000, 24'hA05838, 24'hA55A3C};
    logic [23:0] exp_b [3] = '{24'hC08040, 24'hC09468, 24'hC39669};
    logic [5:0]  exp_h [4] = '{6'h10, 6'h18, 6'h20, 6'h20};

    text_color_attribute_regs u_text_color_attribute_regs (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .task_busy,
        .line_gap_px, .char_space_px, .fore_color, .back_color, .color_depth,
        .user_glyph_start_addr, .glyph_height_sel, .glyph_height_dots, .busy_write_seen);

    initial forever #2.5 pclk = ~pclk;

    task automatic end_sim;
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            end_sim;
        end
    end

    // Leaves one idle cycle after each transfer, so no signal is driven twice in a step
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(1'b0, rows[i][31:24], 8'h00);
            chk("reset value", {24'h0, rows[i][15:8]}, rd);
        end
        chk("bus resp", 32'h1, {30'h0, pslverr, pready});
        foreach (rows[i]) begin
            xfer(1'b1, rows[i][31:24], rows[i][23:16]);
            xfer(1'b0, rows[i][31:24], 8'h00);
            chk("read back", {24'h0, rows[i][7:0]}, rd);
        end
        @(negedge pclk);
        chk("line gap", 32'h1F, {27'h0, line_gap_px});
        chk("spacing", 32'h3F, {26'h0, char_space_px});
        chk("glyph addr", 32'h44332211, user_glyph_start_addr);
        for (int d = 0; d < 3; d++) begin
            xfer(1'b1, `IDX_COLOR_DEPTH, d[7:0]);
            @(negedge pclk);
            chk("depth", d, {30'h0, color_depth});
            chk("fore", {8'h0, exp_f[d]}, {8'h0, fore_color});
            chk("back", {8'h0, exp_b[d]}, {8'h0, back_color});
        end
        // Code 3 is refused, so the last height stays at 32 dots
        for (int h = 0; h < 4; h++) begin
            xfer(1'b1, `IDX_GLYPH_HEIGHT, h[7:0]);
            @(negedge pclk);
            chk("dots", {26'h0, exp_h[h]}, {26'h0, glyph_height_dots});
            chk("height sel", (h == 3) ? 2 : h, {30'h0, glyph_height_sel});
        end
        @(posedge pclk);
        task_busy <= 1'b1;
        // Busy input passes a synchroniser of a few cycles
        repeat (8) @(posedge pclk);
        xfer(1'b1, `IDX_LINE_GAP, 8'h0A);
        task_busy <= 1'b0;
        @(negedge pclk);
        chk("busy flag", 32'h1, {31'h0, busy_write_seen});
        chk("gap landed", 32'h0A, {27'h0, line_gap_px});
        xfer(1'b1, `IDX_COLOR_DEPTH, 8'h80);
        @(negedge pclk);
        chk("busy clear", 32'h0, {31'h0, busy_write_seen});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("fore rst", 32'hE0E0C0, {8'h0, fore_color});
        chk("back rst", 32'h0, {8'h0, back_color});
        chk("glyph rst", 32'h0, user_glyph_start_addr);
        end_sim;
    end
endmodule // text_color_attribute_regs_tb_top
